//--- logic/i2c_bus_host.sv
// Host end of the two-wire link: byte-level controller driven by simple
// START, STOP, WRITE and READ commands; also drives the sensor enable pin.
// Assumes no clock stretching by the target; SCL is made here by a divider.
`timescale 1ns/100ps
`default_nettype none
module i2c_bus_host (
    input wire logic sys_clk,
    input wire logic arst_n,
    i2c_link_if.host link,
    input wire logic en_ctl,
    input wire logic [1:0] speed,
    input wire logic cmd_valid,
    input wire logic [1:0] cmd_op,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_nack,
    output logic cmd_ready,
    output logic done,
    output logic [7:0] rx_data,
    output logic ack_seen,
    output logic en
);
    logic sda_s;
    i2c_link_pkg::host_state_e state;
    logic [7:0] qcnt;
    logic [1:0] phase;
    logic [3:0] cnt;
    logic [7:0] tx;
    logic is_read;
    logic nack;
    logic scl_low;
    logic sda_low;

    // ==========================================================
    // Data line sampling
    sync2 #(.WIDTH(1), .RST_VAL(1'b1)) u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .d(link.sda),
        .q(sda_s)
    );

    // Quarter-bit length per speed grade
    wire [7:0] q_len = (speed == i2c_link_pkg::SPEED_FPLUS) ? i2c_link_pkg::Q_FPLUS_CYC :
                       (speed == i2c_link_pkg::SPEED_FAST) ? i2c_link_pkg::Q_FAST_CYC :
                       i2c_link_pkg::Q_STD_CYC;
    wire tick = (qcnt == 8'h00);
    wire busy = (state != i2c_link_pkg::H_IDLE);
    wire last_phase = tick && (phase == i2c_link_pkg::PH_FALL);
    wire ack_bit = (cnt == i2c_link_pkg::BYTE_BITS);
    wire finish = last_phase && ((state != i2c_link_pkg::H_BIT) || ack_bit);
    wire accept = cmd_valid && cmd_ready;

    // ==========================================================
    // Quarter-bit divider and phase count; only runs during a command
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            qcnt <= 8'h00;
            phase <= i2c_link_pkg::PH_DRIVE;
        end else if (accept || !busy) begin
            qcnt <= q_len - 8'h01;
            phase <= i2c_link_pkg::PH_DRIVE;
        end else if (tick) begin
            qcnt <= q_len - 8'h01;
            phase <= phase + 2'h1;
        end else begin
            qcnt <= qcnt - 8'h01;
        end
    end

    // ==========================================================
    // Command sequencer; the user strings bytes into transactions
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= i2c_link_pkg::H_IDLE;
            cmd_ready <= 1'b1;
            done <= 1'b0;
            cnt <= 4'h0;
            tx <= 8'h00;
            is_read <= 1'b0;
            nack <= 1'b0;
        end else if (accept) begin
            cmd_ready <= 1'b0;
            done <= 1'b0;
            cnt <= 4'h0;
            tx <= cmd_data;
            is_read <= (cmd_op == i2c_link_pkg::OP_READ);
            nack <= cmd_nack;
            case (cmd_op)
                i2c_link_pkg::OP_START: state <= i2c_link_pkg::H_START;
                i2c_link_pkg::OP_STOP: state <= i2c_link_pkg::H_STOP;
                default: state <= i2c_link_pkg::H_BIT;
            endcase
        end else if (finish) begin
            state <= i2c_link_pkg::H_IDLE;
            cmd_ready <= 1'b1;
            done <= 1'b1;
        end else begin
            done <= 1'b0;
            if (last_phase) begin
                cnt <= cnt + 4'h1;
                tx <= {tx[6:0], 1'b0};
            end
        end
    end

    // ==========================================================
    // Line drive per quarter; START from low SCL also gives repeated START
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_low <= 1'b0;
            sda_low <= 1'b0;
            rx_data <= 8'h00;
            ack_seen <= 1'b0;
        end else if (busy && tick) begin
            case (state)
                i2c_link_pkg::H_START: begin
                    if (phase == i2c_link_pkg::PH_DRIVE) begin
                        sda_low <= 1'b0;
                        scl_low <= 1'b1;
                    end
                    if (phase == i2c_link_pkg::PH_RISE) scl_low <= 1'b0;
                    if (phase == i2c_link_pkg::PH_SAMPLE) sda_low <= 1'b1;
                    if (phase == i2c_link_pkg::PH_FALL) scl_low <= 1'b1;
                end
                i2c_link_pkg::H_STOP: begin
                    if (phase == i2c_link_pkg::PH_DRIVE) begin
                        sda_low <= 1'b1;
                        scl_low <= 1'b1;
                    end
                    if (phase == i2c_link_pkg::PH_RISE) scl_low <= 1'b0;
                    if (phase == i2c_link_pkg::PH_SAMPLE) sda_low <= 1'b0;
                end
                i2c_link_pkg::H_BIT: begin
                    if (phase == i2c_link_pkg::PH_DRIVE) begin
                        scl_low <= 1'b1;
                        if (is_read) sda_low <= ack_bit & ~nack;
                        else sda_low <= ~ack_bit & ~tx[7];
                    end
                    if (phase == i2c_link_pkg::PH_RISE) scl_low <= 1'b0;
                    if (phase == i2c_link_pkg::PH_SAMPLE) begin
                        if (is_read && !ack_bit) rx_data <= {rx_data[6:0], sda_s};
                        if (!is_read && ack_bit) ack_seen <= ~sda_s;
                    end
                    if (phase == i2c_link_pkg::PH_FALL) scl_low <= 1'b1;
                end
                default: begin
                    scl_low <= 1'b0;
                end
            endcase
        end
    end

    // Enable pin follows the user request; one sensor at a time is the user's job
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            en <= 1'b0;
        end else begin
            en <= en_ctl;
        end
    end

    // ==========================================================
    // Open-drain outputs: value fixed low, enable low while pulling
    assign link.scl_o = 1'b0;
    assign link.scl_oe_n = ~scl_low;
    assign link.sda_h_o = 1'b0;
    assign link.sda_h_oe_n = ~sda_low;
    assign link.en = en;
endmodule : i2c_bus_host
`default_nettype wire

//--- logic/i2c_link_if.sv
// Open-drain two-wire link plus the enable pin between host and target.
// Assumes pull-ups: a line nobody drives low reads high.
`timescale 1ns/100ps
`default_nettype none
interface i2c_link_if;
    logic scl_o;
    logic scl_oe_n;
    logic sda_h_o;
    logic sda_h_oe_n;
    logic sda_t_o;
    logic sda_t_oe_n;
    logic en;
    logic scl;
    logic sda;

    // ==========================================================
    // Wired-AND resolution of the bus lines
    assign scl = scl_oe_n ? 1'b1 : scl_o;
    assign sda = (sda_h_oe_n ? 1'b1 : sda_h_o) & (sda_t_oe_n ? 1'b1 : sda_t_o);

    modport host (output scl_o, output scl_oe_n, output sda_h_o, output sda_h_oe_n,
                  output en, input sda);
    modport target (input scl, input sda, input en, output sda_t_o, output sda_t_oe_n);
endinterface : i2c_link_if
`default_nettype wire

//--- logic/i2c_link_pkg.sv
// Shared constants, types and helpers for the two-wire register link.
// Assumes a single 40 MHz system clock on both ends of the link.
`default_nettype none
package i2c_link_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int Q_STD_NS = 2500; // Quarter bit, 100 kHz
    localparam int Q_FAST_NS = 625; // Quarter bit, 400 kHz
    localparam int Q_FPLUS_NS = 250; // Quarter bit, 1 MHz

    // Least time, so round up to whole cycles
    function automatic int ns_to_cycles(input int ns);
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction : ns_to_cycles

    localparam logic [7:0] Q_STD_CYC = 8'(ns_to_cycles(Q_STD_NS));
    localparam logic [7:0] Q_FAST_CYC = 8'(ns_to_cycles(Q_FAST_NS));
    localparam logic [7:0] Q_FPLUS_CYC = 8'(ns_to_cycles(Q_FPLUS_NS));

    // ==========================================================
    // Protocol constants
    localparam logic [6:0] DEFAULT_ADDR = 7'h41;
    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [1:0] SPEED_STD = 2'h0;
    localparam logic [1:0] SPEED_FAST = 2'h1;
    localparam logic [1:0] SPEED_FPLUS = 2'h2;
    localparam logic [1:0] OP_START = 2'h0;
    localparam logic [1:0] OP_STOP = 2'h1;
    localparam logic [1:0] OP_WRITE = 2'h2;
    localparam logic [1:0] OP_READ = 2'h3;
    localparam logic [1:0] PH_DRIVE = 2'h0;
    localparam logic [1:0] PH_RISE = 2'h1;
    localparam logic [1:0] PH_SAMPLE = 2'h2;
    localparam logic [1:0] PH_FALL = 2'h3;

    // ==========================================================
    // State types
    typedef enum logic [4:0] {
        T_IDLE = 5'b00001,
        T_RX = 5'b00010,
        T_ACK = 5'b00100,
        T_TX = 5'b01000,
        T_RACK = 5'b10000
    } target_state_e;

    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_START = 4'b0010,
        H_BIT = 4'b0100,
        H_STOP = 4'b1000
    } host_state_e;

    // Pointer step; 8-bit arithmetic wraps 0xff to 0x00
    function automatic logic [7:0] ptr_inc(input logic [7:0] p);
        return p + 8'h01;
    endfunction : ptr_inc
endpackage : i2c_link_pkg
`default_nettype wire

//--- logic/i2c_register_target.sv
// Target end of the two-wire link: address match, register pointer, byte
// transfer to and from a register space on the user side.
// Assumes the host never stretches or glitches SCL and that reg_rdata shows
// the register at reg_addr in the same cycle (combinational read).
`timescale 1ns/100ps
`default_nettype none
module i2c_register_target (
    input wire logic sys_clk,
    input wire logic arst_n,
    i2c_link_if.target link,
    input wire logic pon,
    input wire logic addr_load,
    input wire logic [6:0] addr_new,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic wake,
    output logic [6:0] bus_addr
);
    logic [2:0] sync_q;
    logic scl_s;
    logic sda_s;
    logic en_s;
    logic scl_p;
    logic sda_p;
    i2c_link_pkg::target_state_e state;
    i2c_link_pkg::target_state_e next_state;
    logic [7:0] shift;
    logic [7:0] next_shift;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] next_ptr;
    logic [7:0] next_wdata;
    logic addr_phase;
    logic next_addr_phase;
    logic ptr_phase;
    logic next_ptr_phase;
    logic read_dir;
    logic next_read_dir;
    logic host_ack;
    logic next_host_ack;
    logic sda_low;
    logic next_sda_low;
    logic next_wr;
    logic next_rd;
    logic next_wake;
    logic load_tx;

    // ==========================================================
    // Pin sampling; SDA and SCL idle high, enable idles low (shutdown)
    sync2 #(.WIDTH(3), .RST_VAL(3'h6)) u_sync (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .d({link.scl, link.sda, link.en}),
        .q(sync_q)
    );
    assign scl_s = sync_q[2];
    assign sda_s = sync_q[1];
    assign en_s = sync_q[0];

    // Previous samples for edge detection
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_p <= 1'b1;
            sda_p <= 1'b1;
        end else begin
            scl_p <= scl_s;
            sda_p <= sda_s;
        end
    end

    // ==========================================================
    // Bus events; a few cycles of latency is far below a fast-plus quarter bit
    wire scl_rise = scl_s & ~scl_p;
    wire scl_fall = ~scl_s & scl_p;
    wire start_det = scl_s & scl_p & sda_p & ~sda_s;
    wire stop_det = scl_s & scl_p & ~sda_p & sda_s;
    wire byte_done = (cnt == i2c_link_pkg::BYTE_BITS);
    wire addr_match = (shift[7:1] == bus_addr);
    wire [7:0] ptr_step = i2c_link_pkg::ptr_inc(reg_addr);

    // ==========================================================
    // Next-state logic of the byte engine
    always_comb begin
        next_state = state;
        next_shift = shift;
        next_cnt = cnt;
        next_ptr = reg_addr;
        next_wdata = reg_wdata;
        next_addr_phase = addr_phase;
        next_ptr_phase = ptr_phase;
        next_read_dir = read_dir;
        next_host_ack = host_ack;
        next_sda_low = sda_low;
        next_wr = 1'b0;
        next_rd = 1'b0;
        next_wake = 1'b0;
        load_tx = 1'b0;
        if (start_det) begin
            // Repeated START may arrive in any state
            next_state = i2c_link_pkg::T_RX;
            next_cnt = 4'h0;
            next_addr_phase = 1'b1;
            next_sda_low = 1'b0;
        end else if (stop_det) begin
            next_state = i2c_link_pkg::T_IDLE;
            next_sda_low = 1'b0;
        end else begin
            case (state)
                i2c_link_pkg::T_RX: begin
                    if (scl_rise) begin
                        next_shift = {shift[6:0], sda_s};
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall && byte_done) begin
                        next_cnt = 4'h0;
                        if (addr_phase) begin
                            next_addr_phase = 1'b0;
                            if (addr_match) begin
                                next_state = i2c_link_pkg::T_ACK;
                                next_sda_low = 1'b1;
                                next_read_dir = shift[0];
                                next_ptr_phase = ~shift[0];
                                next_wake = ~pon;
                            end else begin
                                next_state = i2c_link_pkg::T_IDLE;
                            end
                        end else if (ptr_phase) begin
                            next_ptr = shift;
                            next_ptr_phase = 1'b0;
                            next_state = i2c_link_pkg::T_ACK;
                            next_sda_low = 1'b1;
                        end else begin
                            next_wdata = shift;
                            next_wr = 1'b1;
                            next_ptr = ptr_step;
                            next_state = i2c_link_pkg::T_ACK;
                            next_sda_low = 1'b1;
                        end
                    end
                end
                i2c_link_pkg::T_ACK: begin
                    if (scl_fall) begin
                        next_sda_low = 1'b0;
                        next_cnt = 4'h0;
                        if (read_dir) begin
                            load_tx = 1'b1;
                        end else begin
                            next_state = i2c_link_pkg::T_RX;
                        end
                    end
                end
                i2c_link_pkg::T_TX: begin
                    if (scl_rise) begin
                        next_cnt = cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (byte_done) begin
                            next_sda_low = 1'b0;
                            next_state = i2c_link_pkg::T_RACK;
                        end else begin
                            next_shift = {shift[6:0], 1'b0};
                            next_sda_low = ~shift[6];
                        end
                    end
                end
                i2c_link_pkg::T_RACK: begin
                    if (scl_rise) begin
                        next_host_ack = ~sda_s;
                    end else if (scl_fall) begin
                        next_cnt = 4'h0;
                        if (host_ack) begin
                            load_tx = 1'b1;
                        end else begin
                            next_sda_low = 1'b0;
                            next_state = i2c_link_pkg::T_IDLE;
                        end
                    end
                end
                default: begin
                    next_state = i2c_link_pkg::T_IDLE;
                end
            endcase
            // Fetch the byte at the pointer and put its MSB on SDA
            if (load_tx) begin
                next_shift = reg_rdata;
                next_sda_low = ~reg_rdata[7];
                next_rd = 1'b1;
                next_ptr = ptr_step;
                next_state = i2c_link_pkg::T_TX;
            end
        end
    end

    // ==========================================================
    // State registers; enable low clears state, bit count, address phase and SDA drive as in shutdown
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            state <= i2c_link_pkg::T_IDLE;
            shift <= 8'h00;
            cnt <= 4'h0;
            addr_phase <= 1'b0;
            ptr_phase <= 1'b0;
            read_dir <= 1'b0;
            host_ack <= 1'b0;
            sda_low <= 1'b0;
        end else if (!en_s) begin
            state <= i2c_link_pkg::T_IDLE;
            cnt <= 4'h0;
            addr_phase <= 1'b0;
            sda_low <= 1'b0;
        end else begin
            state <= next_state;
            shift <= next_shift;
            cnt <= next_cnt;
            addr_phase <= next_addr_phase;
            ptr_phase <= next_ptr_phase;
            read_dir <= next_read_dir;
            host_ack <= next_host_ack;
            sda_low <= next_sda_low;
        end
    end

    // User-side outputs; pointer survives STOP, only enable low clears it
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_addr <= i2c_link_pkg::PTR_RESET;
            reg_wdata <= 8'h00;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            wake <= 1'b0;
        end else if (!en_s) begin
            reg_addr <= i2c_link_pkg::PTR_RESET;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            wake <= 1'b0;
        end else begin
            reg_addr <= next_ptr;
            reg_wdata <= next_wdata;
            reg_wr <= next_wr;
            reg_rd <= next_rd;
            wake <= next_wake;
        end
    end

    // Own address; the default returns whenever the enable pin drops
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_addr <= i2c_link_pkg::DEFAULT_ADDR;
        end else if (!en_s) begin
            bus_addr <= i2c_link_pkg::DEFAULT_ADDR;
        end else if (addr_load) begin
            bus_addr <= addr_new;
        end
    end

    // ==========================================================
    // Open-drain SDA: value fixed low, enable low while pulling
    assign link.sda_t_o = 1'b0;
    assign link.sda_t_oe_n = ~sda_low;
endmodule : i2c_register_target
`default_nettype wire

//--- logic/sync2.sv
// Two-flop synchroniser for levels entering the system clock domain.
// Assumes inputs are asynchronous pins; reset value set per bit.
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta;

    // ==========================================================
    // First stage feeds only the second stage
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta <= RST_VAL;
            q <= RST_VAL;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule : sync2
`default_nettype wire

//--- test/i2c_link_checker.sv
// Checker for the two-wire link joining host and target ends.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/100ps
`default_nettype none
module i2c_link_checker (
    input wire logic sys_clk,
    input wire logic arst_n,
    input wire logic scl,
    input wire logic sda,
    input wire logic sda_t_oe_n,
    input wire logic sda_h_oe_n,
    input wire logic en
);
    // ==========================================================
    // Wire rules; en guards allow for the target's enable sync delay
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    property p_off; !en [*6] |-> sda_t_oe_n; endproperty
    a_off: assert property (p_off) else $error("target drives while disabled");
    property p_ack; $fell(sda_t_oe_n) |-> !scl; endproperty
    a_ack: assert property (p_ack) else $error("target pulls sda in scl high");
    property p_rel; $rose(sda_t_oe_n) && en && $past(en, 4) |-> !scl; endproperty
    a_rel: assert property (p_rel) else $error("target frees sda in scl high");
    property p_hold; scl && $past(scl) && en && $past(en, 4) |-> $stable(sda_t_oe_n); endproperty
    a_hold: assert property (p_hold) else $error("target sda moved in scl high");
    property p_clash; !sda_t_oe_n && scl |-> sda_h_oe_n; endproperty
    a_clash: assert property (p_clash) else $error("both ends drive sda");
    property p_start; $fell(sda) && scl |-> sda_t_oe_n; endproperty
    a_start: assert property (p_start) else $error("target drives at start");
    property p_rate; $fell(scl) |-> ##[1:300] scl; endproperty
    a_rate: assert property (p_rate) else $error("scl low too long");
    property p_stop; $rose(sda) && scl |=> sda_t_oe_n [*3]; endproperty
    a_stop: assert property (p_stop) else $error("target drives after stop");
    // Main scenarios reached
    c_ack: cover property ($fell(sda_t_oe_n));
    c_start: cover property ($fell(sda) && scl);
    c_stop: cover property ($rose(sda) && scl);
endmodule : i2c_link_checker
`default_nettype wire

//--- test/i2c_register_target_bench.sv
// Bench joining host and target ends, with a register space model.
// Assumes the design files and package are compiled first.
`timescale 1ns/100ps
`default_nettype none
module i2c_register_target_bench;
    logic sys_clk = 1'b0;
    logic arst_n = 1'b0;
    logic en_ctl = 1'b1;
    logic [1:0] speed = 2'h2;
    logic cmd_valid = 1'b0;
    logic [1:0] cmd_op = 2'h0;
    logic [7:0] cmd_data = 8'h00;
    logic cmd_nack = 1'b0;
    logic pon = 1'b1;
    logic addr_load = 1'b0;
    logic [6:0] addr_new = 7'h00;
    logic cmd_ready, done, ack_seen, en, reg_wr, reg_rd, wake;
    logic [7:0] rx_data, reg_addr, reg_wdata, reg_rdata;
    logic [6:0] bus_addr;
    logic [7:0] mem [256];
    int n_fail = 0;
    int num_checks = 0;
    int n_wake = 0;
    int n_rd = 0;
    // ==========================================================
    // Clock, register space and wake counter
    always #12.5 sys_clk = ~sys_clk;
    assign reg_rdata = mem[reg_addr];
    // Pointer has already stepped when reg_wr shows
    always @(posedge sys_clk) if (reg_wr === 1'b1) mem[reg_addr - 8'h01] <= reg_wdata;
    always @(posedge sys_clk) if (wake === 1'b1) n_wake++;
    always @(posedge sys_clk) if (reg_rd === 1'b1) n_rd++;
    // ==========================================================
    // Both ends and the link
    i2c_link_if i2c_link_if_inst ();
    i2c_bus_host i2c_bus_host_inst (.sys_clk(sys_clk), .arst_n(arst_n), .link(i2c_link_if_inst),
        .en_ctl(en_ctl), .speed(speed), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_data(cmd_data),
        .cmd_nack(cmd_nack), .cmd_ready(cmd_ready), .done(done), .rx_data(rx_data), .ack_seen(ack_seen), .en(en));
    i2c_register_target i2c_register_target_inst (.sys_clk(sys_clk), .arst_n(arst_n), .link(i2c_link_if_inst),
        .pon(pon), .addr_load(addr_load), .addr_new(addr_new), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .wake(wake), .bus_addr(bus_addr));
    i2c_link_checker i2c_link_checker_inst (.sys_clk(sys_clk), .arst_n(arst_n), .scl(i2c_link_if_inst.scl),
        .sda(i2c_link_if_inst.sda), .sda_t_oe_n(i2c_link_if_inst.sda_t_oe_n),
        .sda_h_oe_n(i2c_link_if_inst.sda_h_oe_n), .en(i2c_link_if_inst.en));
    // ==========================================================
    // Tasks; every one is entered at a falling edge
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : cmp8
    // Held until the accepting edge; bounded wait for done
    task automatic op(input logic [1:0] o, input logic [7:0] d, input logic nk);
        int i;
        cmd_op = o;
        cmd_data = d;
        cmd_nack = nk;
        cmd_valid = 1'b1;
        @(negedge sys_clk);
        cmd_valid = 1'b0;
        cmp8({7'h0, cmd_ready}, 8'h00);
        for (i = 0; i < 4000 && done !== 1'b1; i++) @(negedge sys_clk);
        cmp8({6'h0, cmd_ready, done}, 8'h03);
        if (done !== 1'b1) give_verdict();
    endtask : op
    task automatic st;
        op(i2c_link_pkg::OP_START, 8'h00, 1'b0);
    endtask : st
    task automatic sp;
        op(i2c_link_pkg::OP_STOP, 8'h00, 1'b0);
    endtask : sp
    task automatic wb(input logic [7:0] d, input logic ea);
        op(i2c_link_pkg::OP_WRITE, d, 1'b0);
        cmp8({7'h0, ack_seen}, {7'h0, ea});
    endtask : wb
    task automatic rb(input logic nk, input logic [7:0] ed);
        op(i2c_link_pkg::OP_READ, 8'h00, nk);
        cmp8(rx_data, ed);
    endtask : rb
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d0, input logic [7:0] d1);
        st();
        wb({a, 1'b0}, 1'b1);
        wb(p, 1'b1);
        wb(d0, 1'b1);
        wb(d1, 1'b1);
        sp();
    endtask : wr
    // ==========================================================
    // Main sequence
    initial begin
        int i;
        for (i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
        repeat (5) @(negedge sys_clk);
        arst_n = 1'b1;
        repeat (6) @(negedge sys_clk);
        cmp8({1'b0, bus_addr}, 8'h41);
        // Writes across the pointer top at fast-plus, fast and standard rates
        for (i = 0; i < 3; i++) begin
            speed = 2'(2 - i);
            wr(7'h41, 8'hfe, 8'ha0 + 8'(i), 8'hb0 + 8'(i));
            cmp8(reg_addr, 8'h00);
        end
        $display("write test done");
        // Rest runs at fast-plus to keep the run short
        speed = i2c_link_pkg::SPEED_FPLUS;
        st();
        wb(8'h82, 1'b1);
        wb(8'hfe, 1'b1);
        st();
        wb(8'h83, 1'b1);
        rb(1'b0, 8'ha2);
        rb(1'b1, 8'hb2);
        sp();
        cmp8({7'h0, i2c_link_if_inst.sda_t_oe_n}, 8'h01);
        st();
        wb(8'h83, 1'b1);
        rb(1'b1, 8'h5a);
        sp();
        cmp8(8'(n_rd), 8'h03);
        $display("read test done");
        // Foreign address is ignored and leaves the pointer alone
        st();
        wb(8'h84, 1'b0);
        sp();
        cmp8(reg_addr, 8'h01);
        addr_new = 7'h23;
        addr_load = 1'b1;
        @(negedge sys_clk);
        addr_load = 1'b0;
        cmp8({1'b0, bus_addr}, 8'h23);
        wr(7'h23, 8'h10, 8'h11, 8'h22);
        cmp8(mem[8'h11], 8'h22);
        cmp8(reg_addr, 8'h12);
        st();
        wb(8'h82, 1'b0);
        sp();
        $display("address test done");
        // Standby still answers and signals a wake
        pon = 1'b0;
        i = n_wake;
        st();
        wb(8'h46, 1'b1);
        sp();
        cmp8(8'(n_wake - i), 8'h01);
        pon = 1'b1;
        // Enable low clears address and pointer
        en_ctl = 1'b0;
        repeat (10) @(negedge sys_clk);
        cmp8({7'h0, en}, 8'h00);
        en_ctl = 1'b1;
        repeat (6) @(negedge sys_clk);
        cmp8({1'b0, bus_addr}, 8'h41);
        cmp8(reg_addr, 8'h00);
        st();
        wb(8'h83, 1'b1);
        rb(1'b1, 8'h5a);
        sp();
        cmp8(8'(n_rd), 8'h04);
        $display("standby and enable test done");
        give_verdict();
    end
endmodule : i2c_register_target_bench
`default_nettype wire
